// File: common/tmcc_pkg.sv
package tmcc_pkg;
    // bus geometry and answers
    localparam int ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // register byte offsets
    localparam logic [7:0] OFF_PINSEL = 8'h00;
    localparam logic [7:0] OFF_IE0 = 8'h04;
    localparam logic [7:0] OFF_IE1 = 8'h08;
    localparam logic [7:0] OFF_IE2 = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_CLR = 8'h14;
    localparam logic [7:0] OFF_EN = 8'h18;
    // reset values and masks
    localparam logic [7:0] PINSEL_RST = 8'h00;
    localparam logic [7:0] IE_RST = 8'h40;
    localparam logic [7:0] IE_FIXED1 = 8'h40;
    localparam logic [7:0] IE0_WMASK = 8'h9F;
    localparam logic [7:0] IE12_WMASK = 8'hB3;
    localparam logic [3:0] EV_RST = 4'h0;
    // field positions
    localparam int CODE_B_LSB = 4;
    localparam int CODE_A_LSB = 0;
    localparam int IE_CONV_BIT = 7;
    localparam int NCH = 3;
    localparam int NFLAG = 6;
    localparam int EV_W = 4;
    // match actions and capture edges, low two code bits
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOG = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    // read channel states
    typedef enum logic [1:0] {
        TMCC_RD_IDLE = 2'b01,
        TMCC_RD_RESP = 2'b10
    } tmcc_rd_e;
    // driven side of a timer pin
    typedef struct packed {
        logic out;
        logic oe;
    } tmcc_pin_s;
endpackage

// File: core/tmcc_top.sv
// Operation
// - bits 7..4 of pin select code register B; 0000 output off, reset value
// - bits 3..0 code register A with the same table; 0000 default
// - codes 00xx compare, pin starts low; 01 low, 10 high, 11 toggle
// - codes 01xx compare, pin starts high; 0100 off, then low, high, toggle
// - codes 10xx capture from own pin: rising, falling, both edges
// - codes 11xx also capture: rising, falling, both; 1x11 does nothing
// - eight-bit enable register gates each request of a channel
// - three enable registers, one per channel
// - enable registers go to 40 hex on reset and on standby
// - bit 7 gates conversion start request from register A event
// - bit 6 of every enable register always reads one
// - overflow enable gates the overflow request with its flag
// - enables A to D gate requests from their status flags; channels 1 and 2 have A and B only
`timescale 1ns/10ps
module tmcc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tmcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tmcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic standby,
    input wire logic [1:0] ch2_match,
    input wire logic [1:0] ch2_pin_in,
    output tmcc_pkg::tmcc_pin_s ch2_pin_a,
    output tmcc_pkg::tmcc_pin_s ch2_pin_b,
    output logic [1:0] ch2_capture,
    input wire logic [tmcc_pkg::NCH-1:0][tmcc_pkg::NFLAG-1:0] chan_flags,
    input wire logic [tmcc_pkg::NCH-1:0] chan_reg_a_event,
    output logic [tmcc_pkg::NCH-1:0][tmcc_pkg::NFLAG-1:0] chan_irq_req,
    output logic [tmcc_pkg::NCH-1:0] conv_start_req,
    output logic irq
);
    // compare codes with a live output
    function automatic logic drives(input logic [3:0] code);
        drives = ~code[3] & (code[1:0] != 2'h0);
    endfunction

    // capture edge test for one code
    function automatic logic cap_hit(input logic [3:0] code, input logic rise,
                                     input logic fall);
        case (code[1:0])
            tmcc_pkg::EDGE_RISE: cap_hit = code[3] & rise;
            tmcc_pkg::EDGE_FALL: cap_hit = code[3] & fall;
            tmcc_pkg::EDGE_BOTH: cap_hit = code[3] & (rise | fall);
            default: cap_hit = 1'b0;
        endcase
    endfunction

    logic [7:0] pinsel_q, pinsel_d;
    logic [tmcc_pkg::NCH-1:0][7:0] ie_q, ie_d;
    logic [tmcc_pkg::EV_W-1:0] stat_q, stat_d, en_q, en_d;
    logic aw_v_q, aw_v_d, w_v_q, w_v_d, bvalid_q, bvalid_d;
    logic [tmcc_pkg::ADDR_W-1:0] aw_a_q, aw_a_d;
    logic [7:0] w_data_q, w_data_d;
    logic w_lane_q, w_lane_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    tmcc_pkg::tmcc_rd_e rd_q, rd_d;
    logic fire, wr_en, sel_wr;
    logic [1:0][2:0] sync_q, sync_d;
    logic [1:0] stable_q, stable_d, level_q, level_d, cap_q, cap_d;
    logic [1:0][3:0] code;
    logic [tmcc_pkg::EV_W-1:0] ev, clr;
    logic [tmcc_pkg::NCH-1:0][tmcc_pkg::NFLAG-1:0] req_q, req_d;
    logic [tmcc_pkg::NCH-1:0] conv_q, conv_d;
    logic irq_q, irq_d;

    // write happens once address and data are both held
    assign fire = aw_v_q & w_v_q & ~bvalid_q;
    assign wr_en = fire & w_lane_q;
    assign sel_wr = wr_en & (aw_a_q == tmcc_pkg::OFF_PINSEL);
    assign code[1] = pinsel_q[tmcc_pkg::CODE_B_LSB +: 4];
    assign code[0] = pinsel_q[tmcc_pkg::CODE_A_LSB +: 4];

    // bus handshakes
    assign s_axi_awready = ~aw_v_q & ~bvalid_q;
    assign s_axi_wready = ~w_v_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = (rd_q == tmcc_pkg::TMCC_RD_IDLE);
    assign s_axi_rvalid = (rd_q == tmcc_pkg::TMCC_RD_RESP);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // bus slave and register next values
    always_comb begin
        aw_v_d = aw_v_q;
        aw_a_d = aw_a_q;
        w_v_d = w_v_q;
        w_data_d = w_data_q;
        w_lane_d = w_lane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rd_d = rd_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        pinsel_d = pinsel_q;
        ie_d = ie_q;
        en_d = en_q;
        clr = '0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_v_d = 1'b1;
            aw_a_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_v_d = 1'b1;
            w_data_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (fire) begin
            aw_v_d = 1'b0;
            w_v_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = tmcc_pkg::RESP_OKAY;
            case (aw_a_q)
                tmcc_pkg::OFF_PINSEL: if (w_lane_q) pinsel_d = w_data_q;
                tmcc_pkg::OFF_IE0: if (w_lane_q) begin
                    ie_d[0] = (w_data_q & tmcc_pkg::IE0_WMASK) | tmcc_pkg::IE_FIXED1;
                end
                tmcc_pkg::OFF_IE1: if (w_lane_q) begin
                    ie_d[1] = (w_data_q & tmcc_pkg::IE12_WMASK) | tmcc_pkg::IE_FIXED1;
                end
                tmcc_pkg::OFF_IE2: if (w_lane_q) begin
                    ie_d[2] = (w_data_q & tmcc_pkg::IE12_WMASK) | tmcc_pkg::IE_FIXED1;
                end
                tmcc_pkg::OFF_STAT: ;
                tmcc_pkg::OFF_CLR: if (w_lane_q) clr = w_data_q[tmcc_pkg::EV_W-1:0];
                tmcc_pkg::OFF_EN: if (w_lane_q) en_d = w_data_q[tmcc_pkg::EV_W-1:0];
                default: bresp_d = tmcc_pkg::RESP_DECERR;
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // standby reinitialises the enables over any write
        if (standby) begin
            ie_d = {tmcc_pkg::NCH{tmcc_pkg::IE_RST}};
        end
        case (rd_q)
            tmcc_pkg::TMCC_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_d = tmcc_pkg::TMCC_RD_RESP;
                    rdata_d = 32'h0000_0000;
                    rresp_d = tmcc_pkg::RESP_OKAY;
                    case (s_axi_araddr)
                        tmcc_pkg::OFF_PINSEL: rdata_d[7:0] = pinsel_q;
                        tmcc_pkg::OFF_IE0: rdata_d[7:0] = ie_q[0] | tmcc_pkg::IE_FIXED1;
                        tmcc_pkg::OFF_IE1: rdata_d[7:0] = ie_q[1] | tmcc_pkg::IE_FIXED1;
                        tmcc_pkg::OFF_IE2: rdata_d[7:0] = ie_q[2] | tmcc_pkg::IE_FIXED1;
                        tmcc_pkg::OFF_STAT: rdata_d[tmcc_pkg::EV_W-1:0] = stat_q;
                        tmcc_pkg::OFF_CLR: ;
                        tmcc_pkg::OFF_EN: rdata_d[tmcc_pkg::EV_W-1:0] = en_q;
                        default: rresp_d = tmcc_pkg::RESP_DECERR;
                    endcase
                end
            end
            tmcc_pkg::TMCC_RD_RESP: begin
                if (s_axi_rready) rd_d = tmcc_pkg::TMCC_RD_IDLE;
            end
            default: rd_d = tmcc_pkg::TMCC_RD_IDLE;
        endcase
    end

    // bus and register flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_q <= 1'b0;
            aw_a_q <= '0;
            w_v_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= tmcc_pkg::RESP_OKAY;
            rd_q <= tmcc_pkg::TMCC_RD_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= tmcc_pkg::RESP_OKAY;
            pinsel_q <= tmcc_pkg::PINSEL_RST;
            ie_q <= {tmcc_pkg::NCH{tmcc_pkg::IE_RST}};
            en_q <= tmcc_pkg::EV_RST;
        end else begin
            aw_v_q <= aw_v_d;
            aw_a_q <= aw_a_d;
            w_v_q <= w_v_d;
            w_data_q <= w_data_d;
            w_lane_q <= w_lane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rd_q <= rd_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            pinsel_q <= pinsel_d;
            ie_q <= ie_d;
            en_q <= en_d;
        end
    end

    // pin sync, compare level and capture edges, index 0 is A, 1 is B
    always_comb begin
        sync_d = sync_q;
        stable_d = stable_q;
        level_d = level_q;
        cap_d = 2'b00;
        for (int i = 0; i < 2; i++) begin
            sync_d[i] = {sync_q[i][1:0], ch2_pin_in[i]};
            if (sync_q[i][1] == sync_q[i][2]) stable_d[i] = sync_q[i][1];
            cap_d[i] = cap_hit(code[i], stable_d[i] & ~stable_q[i],
                               ~stable_d[i] & stable_q[i]);
            if (sel_wr) begin
                level_d[i] = w_data_q[4*i+2];
            end else if (~code[i][3] && ch2_match[i]) begin
                case (code[i][1:0])
                    tmcc_pkg::ACT_LOW: level_d[i] = 1'b0;
                    tmcc_pkg::ACT_HIGH: level_d[i] = 1'b1;
                    tmcc_pkg::ACT_TOG: level_d[i] = ~level_q[i];
                    default: level_d[i] = level_q[i];
                endcase
            end
        end
    end

    // pin flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_q <= '0;
            stable_q <= 2'b00;
            level_q <= 2'b00;
            cap_q <= 2'b00;
        end else begin
            sync_q <= sync_d;
            stable_q <= stable_d;
            level_q <= level_d;
            cap_q <= cap_d;
        end
    end

    assign ch2_pin_a.out = level_q[0];
    assign ch2_pin_a.oe = drives(code[0]);
    assign ch2_pin_b.out = level_q[1];
    assign ch2_pin_b.oe = drives(code[1]);
    assign ch2_capture = cap_q;

    // sticky events, request gating and the interrupt line
    always_comb begin
        ev = {cap_q, ch2_match & ~{code[1][3], code[0][3]}};
        stat_d = (stat_q & ~clr) | ev; // set beats clear
        irq_d = |(stat_d & en_d);
        for (int c = 0; c < tmcc_pkg::NCH; c++) begin
            req_d[c] = chan_flags[c] & ie_q[c][tmcc_pkg::NFLAG-1:0];
            conv_d[c] = chan_reg_a_event[c] & ie_q[c][tmcc_pkg::IE_CONV_BIT];
        end
    end

    // event flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= tmcc_pkg::EV_RST;
            irq_q <= 1'b0;
            req_q <= '0;
            conv_q <= '0;
        end else begin
            stat_q <= stat_d;
            irq_q <= irq_d;
            req_q <= req_d;
            conv_q <= conv_d;
        end
    end

    assign chan_irq_req = req_q;
    assign conv_start_req = conv_q;
    assign irq = irq_q;
endmodule // tmcc_top

// File: verif/tmcc_pin_model.sv
`timescale 1ns/10ps
// far side of the channel 2 pins, A in bit 0 and B in bit 1
module tmcc_pin_model (
    input wire tmcc_pkg::tmcc_pin_s pin_a,
    input wire tmcc_pkg::tmcc_pin_s pin_b,
    input wire logic [1:0] drive,
    output logic [1:0] level
);
    // device output wins while enabled, else the outside source feeds capture
    assign level[0] = pin_a.oe ? pin_a.out : drive[0];
    assign level[1] = pin_b.oe ? pin_b.out : drive[1];
endmodule // tmcc_pin_model

// File: verif/tmcc_properties.sv
`timescale 1ns/10ps
module tmcc_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] ch2_match,
    input wire tmcc_pkg::tmcc_pin_s ch2_pin_a,
    input wire tmcc_pkg::tmcc_pin_s ch2_pin_b,
    input wire logic [1:0] ch2_capture,
    input wire logic [tmcc_pkg::NCH-1:0][tmcc_pkg::NFLAG-1:0] chan_flags,
    input wire logic [tmcc_pkg::NCH-1:0] chan_reg_a_event,
    input wire logic [tmcc_pkg::NCH-1:0][tmcc_pkg::NFLAG-1:0] chan_irq_req,
    input wire logic [tmcc_pkg::NCH-1:0] conv_start_req,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // register answers
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // requests only where their cause was present
    a_req_gated: assert property ((chan_irq_req & ~$past(chan_flags)) == '0)
        else $error("request without flag");
    a_conv_gated: assert property ((conv_start_req & ~$past(chan_reg_a_event)) == '0)
        else $error("conversion start without event");
    // pin level moves only on a match or a register write
    a_out_a_cause: assert property (!$stable(ch2_pin_a.out) |-> $past(ch2_match[0])
        || $rose(s_axi_bvalid)) else $error("pin a moved without cause");
    a_out_b_cause: assert property (!$stable(ch2_pin_b.out) |-> $past(ch2_match[1])
        || $rose(s_axi_bvalid)) else $error("pin b moved without cause");
    // capture only while the pin is an input
    a_cap_a_input: assert property (ch2_capture[0] |-> !ch2_pin_a.oe)
        else $error("capture a while driving");
    a_cap_b_input: assert property (ch2_capture[1] |-> !ch2_pin_b.oe)
        else $error("capture b while driving");
    c_irq: cover property ($rose(irq));
    c_conv: cover property (|conv_start_req);
    c_cap: cover property (|ch2_capture);
endmodule // tmcc_properties

bind tmcc_top tmcc_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .ch2_match, .ch2_pin_a, .ch2_pin_b, .ch2_capture, .chan_flags,
    .chan_reg_a_event, .chan_irq_req, .conv_start_req, .irq);

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tmcc_row_s;
    logic aclk, aresetn, standby, ex, ef, eo;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb, code;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, drv, ch2_match, ch2_pin_in, ch2_capture;
    tmcc_pkg::tmcc_pin_s ch2_pin_a, ch2_pin_b;
    logic [2:0][5:0] chan_flags, chan_irq_req;
    logic [2:0] chan_reg_a_event, conv_start_req;
    logic irq;
    int failures, n_compared, ncap, n0;
    tmcc_row_s rows [8];
    tmcc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .standby, .ch2_match, .ch2_pin_in, .ch2_pin_a,
        .ch2_pin_b, .ch2_capture, .chan_flags, .chan_reg_a_event, .chan_irq_req,
        .conv_start_req, .irq);
    tmcc_pin_model pins (.pin_a(ch2_pin_a), .pin_b(ch2_pin_b), .drive(drv), .level(ch2_pin_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // write: both halves offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        // no cycle count assumed: only the watchdog ends a wait for the answer
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp; s_axi_bready <= 0; @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; @(posedge aclk);
    endtask
    initial begin
        aclk = 0;
        forever #2 aclk = ~aclk;
    end
    // captures seen on both pins
    always @(posedge aclk) ncap <= ncap + ch2_capture[0] + ch2_capture[1];
    initial begin
        #40000; failures++; report_and_stop();
    end
    initial begin
        {aresetn, standby, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {drv, ch2_match, chan_flags, chan_reg_a_event} = '0;
        s_axi_wstrb = 4'hF;
        rows = '{'{8'h04, 32'hFF, 32'hDF, 2'h0}, '{8'h08, 32'hFF, 32'hF3, 2'h0},
            '{8'h0C, 32'h00, 32'h40, 2'h0}, '{8'h00, 32'h5A, 32'h5A, 2'h0},
            '{8'h10, 32'hFF, 32'h00, 2'h0}, '{8'h14, 32'hFF, 32'h00, 2'h0},
            '{8'h18, 32'hFF, 32'h0F, 2'h0}, '{8'h20, 32'hFF, 32'h00, tmcc_pkg::RESP_DECERR}};
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rsp);
            chk(rsp, rows[i].r);
            rd(rows[i].a, rdv, rsp);
            chk(rdv, rows[i].e);
            chk(rsp, rows[i].r);
        end
        // channel requests gated by the enables written above
        chan_flags <= '1; chan_reg_a_event <= 3'h7;
        @(posedge aclk);
        chan_reg_a_event <= 3'h0;
        // look between edges, while the one-cycle pulse stands
        @(negedge aclk);
        chk(conv_start_req, 32'h3);
        chk(chan_irq_req, {6'h00, 6'h33, 6'h1F});
        @(posedge aclk);
        chan_flags <= '0;
        // every code: enable, start level, match action
        for (int c = 0; c < 16; c++) begin
            code = 4'(c);
            wr(8'h00, {24'h0, code, code}, rsp);
            eo = code[3] ? code[2] : code[1:0] == tmcc_pkg::ACT_LOW ? 1'b0
                : code[1:0] == tmcc_pkg::ACT_HIGH ? 1'b1
                : code[1:0] == tmcc_pkg::ACT_TOG ? ~code[2] : code[2];
            chk({ch2_pin_a.oe, ch2_pin_b.oe}, {2{!code[3] && code[1:0] != 2'h0}});
            chk({ch2_pin_a.out, ch2_pin_b.out}, {2{code[2]}});
            ch2_match <= 2'h3;
            @(posedge aclk);
            ch2_match <= 2'h0;
            @(posedge aclk);
            chk({ch2_pin_a.out, ch2_pin_b.out}, {2{eo}});
        end
        // capture codes against a rising then a falling pin
        for (int c = 8; c < 16; c++) begin
            code = 4'(c);
            wr(8'h00, {24'h0, code, code}, rsp);
            ex = code[1:0] == tmcc_pkg::EDGE_RISE || code[1:0] == tmcc_pkg::EDGE_BOTH;
            ef = code[1:0] == tmcc_pkg::EDGE_FALL || code[1:0] == tmcc_pkg::EDGE_BOTH;
            repeat (6) @(posedge aclk);
            n0 = ncap; drv <= 2'h3;
            repeat (8) @(posedge aclk);
            chk(ncap - n0, 2 * ex);
            drv <= 2'h0;
            repeat (8) @(posedge aclk);
            chk(ncap - n0, 2 * (ex + ef));
        end
        // status, mask and clear of the block interrupt
        rd(8'h10, rdv, rsp);
        chk(rdv, 32'h0F);
        chk(irq, 1'b1);
        wr(8'h18, 32'h00, rsp);
        chk(irq, 1'b0);
        wr(8'h18, 32'h04, rsp);
        chk(irq, 1'b1);
        wr(8'h14, 32'h04, rsp);
        chk(irq, 1'b0);
        rd(8'h10, rdv, rsp);
        chk(rdv, 32'h0B);
        // standby holds every enable register at its initial value
        standby <= 1'b1;
        wr(8'h04, 32'hFF, rsp);
        standby <= 1'b0;
        for (int i = 1; i < 4; i++) begin
            rd(8'(4 * i), rdv, rsp);
            chk(rdv, 32'h40);
        end
        // reset in mid-run
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk({ch2_pin_a.oe, ch2_pin_b.oe, irq}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(i == 5 ? 8'h18 : 8'(4 * i), rdv, rsp);
            chk(rdv, (i > 0 && i < 4) ? 32'h40 : 32'h00);
        end
        // a write without its low byte lane stores nothing
        s_axi_wstrb <= 4'hE;
        wr(8'h00, 32'h33, rsp);
        chk(rsp, tmcc_pkg::RESP_OKAY);
        chk({ch2_pin_a.oe, ch2_pin_b.oe}, 32'h0);
        s_axi_wstrb <= 4'hF;
        rd(8'h00, rdv, rsp);
        chk(rdv, 32'h00);
        report_and_stop();
    end
endmodule // tb
